// >>> verilog/uhpc_hub_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Fetch configuration and identifiers from serial memory before attaching upstream.
// - After fetch and with bus voltage present, enable D+ pull-up, await reset.
// - During upstream bus reset, emit device chirp announcing high-speed ability.
// - On host chirp answer, enter high-speed and drop the D+ pull-up.
// - Without host chirp answer, keep running as a full-speed hub.
// - After any bus reset, address and configuration value are zero.
// - Full hub function only once a nonzero configuration is selected.
// - Four ports at most; usable and removable flags from extended loads.
// - Before configuration, every port drives SE0 and stays unpowered.
// - After configuration release the lines; host powers ports individually.
// - Detect connect and disconnect on powered ports; report via status endpoint.
// - Port reset request: reset, enable, green indicator unless overridden, babble detect.
// - Non-idle line after EOF2 on an enabled port disables it.
// - Clear-enable request disables the named port.
// - Suspend request suspends only the named port.
// - Wakeup on suspended port with hub awake sets a port change.
// - Wakeup on suspended port with hub suspended is forwarded upstream.
// - Clear-suspend request resumes the suspended port.
// - High-speed hub: slower devices via translator, high-speed devices via repeater.
// - Full-speed hub: high-speed devices run at full speed only.
// - Upstream transmitter blocks downstream babble and disconnects from going upstream.
// - Repeater connects and releases only on packet boundaries, handles suspend.
module uhpc_hub_ctrl #(
  parameter int RESET_CYC = uhpc_pkg::PORT_RESET_CYC,
  parameter int RESUME_CYC = uhpc_pkg::PORT_RESUME_CYC,
  parameter int CHIRP_CYC = uhpc_pkg::DEV_CHIRP_CYC,
  parameter int SPI_HALF = uhpc_pkg::SPI_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  output logic spi_cs_n_o,
  output logic spi_sck_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i,
  output logic cfg_done_o,
  output logic [15:0] cfg_vid_o,
  output logic [15:0] cfg_pid_o,
  output logic [15:0] cfg_did_o,
  output logic [3:0] port_usable_o,
  output logic [3:0] port_removable_o,
  input wire logic upstream_vbus_sense_i,
  input wire logic bus_reset_i,
  input wire logic host_chirp_i,
  output logic dp_pullup_o,
  output logic chirp_k_o,
  output logic hs_mode_o,
  input wire logic set_addr_i,
  input wire logic [6:0] addr_i,
  input wire logic set_cfg_i,
  input wire logic [7:0] cfg_val_i,
  output logic [6:0] dev_addr_o,
  output logic [7:0] cfg_value_o,
  output logic hub_ready_o,
  input wire logic req_valid_i,
  input wire uhpc_pkg::uhpc_req_t req_code_i,
  input wire logic [1:0] req_port_i,
  output logic req_ready_o,
  input wire logic hub_suspended_i,
  input wire logic eof2_i,
  input wire logic pkt_boundary_i,
  input wire logic [3:0] port_connect_i,
  input wire logic [3:0] port_nonidle_i,
  input wire logic [3:0] port_hs_dev_i,
  input wire logic [3:0] port_wakeup_i,
  output logic [3:0] port_se0_o,
  output logic [3:0] port_power_o,
  output logic [3:0] port_reset_o,
  output logic [3:0] port_enabled_o,
  output logic [3:0] port_suspended_o,
  output logic [3:0] port_resume_o,
  output logic [3:0] ind_green_o,
  output logic [3:0] babble_en_o,
  output logic [3:0] route_tt_o,
  output logic [3:0] rep_conn_o,
  output logic [3:0] us_block_o,
  output logic fs_only_o,
  output logic upstream_wakeup_o,
  output logic sc_valid_o,
  input wire logic sc_ready_i,
  output logic [4:0] sc_data_o
);

  localparam int NP = uhpc_pkg::NPORT;
  localparam int RX_W = uhpc_pkg::CFG_BYTES * 8;
  localparam int ALL_BITS = uhpc_pkg::SPI_CMD_BITS + RX_W;
  localparam int SC_W_L = uhpc_pkg::SC_W;

  typedef enum logic [2:0] {
    US_FETCH, US_WAIT_VBUS, US_ATTACHED, US_CHIRP, US_WAIT_HOST, US_FS_RUN, US_HS_RUN
  } uhpc_us_t;

  typedef enum logic [2:0] {
    PS_OFF, PS_DISC, PS_DISABLED, PS_RESETTING, PS_ENABLED, PS_SUSPENDED, PS_RESUMING
  } uhpc_ps_t;

  // Picks byte idx of the fetched image; the first byte read sits on top.
  function automatic logic [7:0] cfg_byte(input logic [RX_W-1:0] img, input int idx);
    cfg_byte = img[(uhpc_pkg::CFG_BYTES - 1 - idx) * 8 +: 8];
  endfunction : cfg_byte

  // True when a valid request of the given code names port p.
  function automatic logic req_hit(input uhpc_pkg::uhpc_req_t code, input int p);
    req_hit = req_valid_i && (req_code_i == code) && (req_port_i == 2'(p));
  endfunction : req_hit

  uhpc_us_t us_q;
  uhpc_ps_t ps_q [NP];
  logic [uhpc_pkg::CNT_W-1:0] pcnt_q [NP];
  logic [uhpc_pkg::CNT_W-1:0] ucnt_q;
  logic [RX_W-1:0] rx_q;
  logic [uhpc_pkg::SPI_CMD_BITS-1:0] tx_q;
  logic [7:0] bit_q;
  logic [7:0] div_q;
  logic fetching_q;
  logic reset_seen_q;
  logic [3:0] conn_q;
  logic [3:0] c_conn_q;
  logic [3:0] c_en_q;
  logic [3:0] c_susp_q;
  logic [3:0] c_rst_q;
  logic [3:0] ind_ovr_q;
  logic [3:0] rep_q;
  logic [SC_W_L-1:0] last_q;
  logic [3:0] ev_babble;
  logic [3:0] ev_rst_done;
  logic [3:0] ev_res_done;
  logic [3:0] ev_conn;
  logic reset_rise;
  logic configured;
  logic running;
  logic [4:0] sc_bits;

  uhpc_sc_if sc_if ();

  // serial fetch
  // Mode 0 serial read: shift on the falling edge, sample on the rising one.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      fetching_q <= 1'b1;
      spi_cs_n_o <= 1'b0;
      spi_sck_o <= 1'b0;
      tx_q <= {uhpc_pkg::SPI_READ_CMD, uhpc_pkg::SPI_START_ADDR};
      rx_q <= '0;
      bit_q <= 8'h00;
      div_q <= 8'h00;
      cfg_done_o <= 1'b0;
    end
    else if (fetching_q)
    begin
      if (div_q == 8'(SPI_HALF - 1))
      begin
        div_q <= 8'h00;
        spi_sck_o <= ~spi_sck_o;
        if (!spi_sck_o && bit_q >= 8'(uhpc_pkg::SPI_CMD_BITS))
          rx_q <= {rx_q[RX_W-2:0], spi_miso_i};
        if (spi_sck_o)
        begin
          tx_q <= {tx_q[uhpc_pkg::SPI_CMD_BITS-2:0], 1'b0};
          bit_q <= bit_q + 8'h01;
          if (bit_q == 8'(ALL_BITS - 1))
          begin
            fetching_q <= 1'b0;
            spi_cs_n_o <= 1'b1;
            cfg_done_o <= 1'b1;
          end
        end
      end
      else
        div_q <= div_q + 8'h01;
    end
  end

  assign spi_mosi_o = tx_q[uhpc_pkg::SPI_CMD_BITS-1];

  // extended loads
  // Port flags count only when the image carries an extended load marker.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cfg_vid_o <= 16'h0000;
      cfg_pid_o <= 16'h0000;
      cfg_did_o <= 16'h0000;
      port_usable_o <= uhpc_pkg::PORTS_ALL;
      port_removable_o <= uhpc_pkg::PORTS_NONE;
    end
    else if (fetching_q && spi_sck_o && div_q == 8'(SPI_HALF - 1) && bit_q == 8'(ALL_BITS - 1))
    begin
      cfg_vid_o <= {cfg_byte(rx_q, uhpc_pkg::BYTE_VID), cfg_byte(rx_q, uhpc_pkg::BYTE_VID + 1)};
      cfg_pid_o <= {cfg_byte(rx_q, uhpc_pkg::BYTE_PID), cfg_byte(rx_q, uhpc_pkg::BYTE_PID + 1)};
      cfg_did_o <= {cfg_byte(rx_q, uhpc_pkg::BYTE_DID), cfg_byte(rx_q, uhpc_pkg::BYTE_DID + 1)};
      if (cfg_byte(rx_q, uhpc_pkg::BYTE_LOAD) == uhpc_pkg::LOAD_EXT_A ||
          cfg_byte(rx_q, uhpc_pkg::BYTE_LOAD) == uhpc_pkg::LOAD_EXT_B)
      begin
        {port_removable_o, port_usable_o} <= cfg_byte(rx_q, uhpc_pkg::BYTE_PORTS);
      end
    end
  end

  assign reset_rise = bus_reset_i && !reset_seen_q;
  assign running = (us_q == US_FS_RUN) || (us_q == US_HS_RUN) || (us_q == US_ATTACHED);

  // Upstream attach and speed negotiation; a vbus loss detaches at once.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      us_q <= US_FETCH;
      ucnt_q <= '0;
      reset_seen_q <= 1'b0;
    end
    else
    begin
      reset_seen_q <= bus_reset_i;
      if (us_q != US_FETCH && !upstream_vbus_sense_i)
        us_q <= US_WAIT_VBUS;
      else
        case (us_q)
          US_FETCH:
            if (cfg_done_o)
              us_q <= US_WAIT_VBUS;
          US_WAIT_VBUS:
            us_q <= US_ATTACHED;
          US_ATTACHED, US_FS_RUN, US_HS_RUN:
            if (reset_rise)
            begin
              us_q <= US_CHIRP;
              ucnt_q <= uhpc_pkg::CNT_W'(CHIRP_CYC - 1);
            end
          US_CHIRP:
            if (!bus_reset_i)
              us_q <= US_FS_RUN;
            else if (ucnt_q == '0)
              us_q <= US_WAIT_HOST;
            else
              ucnt_q <= ucnt_q - 1'b1;
          US_WAIT_HOST:
            if (host_chirp_i)
              us_q <= US_HS_RUN;
            else if (!bus_reset_i)
              us_q <= US_FS_RUN;
          default:
            us_q <= US_FETCH;
        endcase
    end
  end

  assign dp_pullup_o = (us_q == US_ATTACHED) || (us_q == US_CHIRP) || (us_q == US_WAIT_HOST) ||
                       (us_q == US_FS_RUN);
  assign chirp_k_o = (us_q == US_CHIRP);
  assign hs_mode_o = (us_q == US_HS_RUN);

  // reset clears address
  // The host's assignments stick only while the link is up and running.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || reset_rise || !running)
    begin
      dev_addr_o <= 7'h00;
      cfg_value_o <= 8'h00;
    end
    else
    begin
      if (set_addr_i)
        dev_addr_o <= addr_i;
      if (set_cfg_i)
        cfg_value_o <= cfg_val_i;
    end
  end

  assign configured = running && (cfg_value_o != 8'h00);
  assign hub_ready_o = configured;
  assign req_ready_o = 1'b1;

  // Events shared by the port machines and the change flags.
  always_comb
  begin
    for (int p = 0; p < NP; p++)
    begin
      ev_babble[p] = (ps_q[p] == PS_ENABLED) && eof2_i && port_nonidle_i[p];
      ev_rst_done[p] = (ps_q[p] == PS_RESETTING) && (pcnt_q[p] == '0) && port_connect_i[p];
      ev_res_done[p] = (ps_q[p] == PS_RESUMING) && (pcnt_q[p] == '0);
      ev_conn[p] = (ps_q[p] != PS_OFF) && (port_connect_i[p] != conn_q[p]);
    end
  end

  // Per-port state machines; unconfigured or unusable ports stay off.
  always_ff @(posedge clk_i)
  begin
    for (int p = 0; p < NP; p++)
    begin
      if (!resetn_i || !configured || !port_usable_o[p])
      begin
        ps_q[p] <= PS_OFF;
        pcnt_q[p] <= '0;
      end
      else if (req_hit(uhpc_pkg::UHPC_REQ_CLR_POWER, p))
        ps_q[p] <= PS_OFF;
      else if (ps_q[p] != PS_OFF && !port_connect_i[p] && ps_q[p] != PS_DISC)
        ps_q[p] <= PS_DISC;
      else
        case (ps_q[p])
          PS_OFF:
            if (req_hit(uhpc_pkg::UHPC_REQ_SET_POWER, p))
              ps_q[p] <= PS_DISC;
          PS_DISC:
            if (port_connect_i[p])
              ps_q[p] <= PS_DISABLED;
          PS_DISABLED:
            if (req_hit(uhpc_pkg::UHPC_REQ_SET_RESET, p))
            begin
              ps_q[p] <= PS_RESETTING;
              pcnt_q[p] <= uhpc_pkg::CNT_W'(RESET_CYC - 1);
            end
          PS_RESETTING:
            if (pcnt_q[p] == '0)
              ps_q[p] <= PS_ENABLED;
            else
              pcnt_q[p] <= pcnt_q[p] - 1'b1;
          PS_ENABLED:
            if (ev_babble[p] || req_hit(uhpc_pkg::UHPC_REQ_CLR_ENABLE, p))
              ps_q[p] <= PS_DISABLED;
            else if (req_hit(uhpc_pkg::UHPC_REQ_SET_SUSPEND, p))
              ps_q[p] <= PS_SUSPENDED;
          PS_SUSPENDED:
            if (req_hit(uhpc_pkg::UHPC_REQ_CLR_ENABLE, p))
              ps_q[p] <= PS_DISABLED;
            else if (req_hit(uhpc_pkg::UHPC_REQ_CLR_SUSPEND, p) ||
                     (port_wakeup_i[p] && !hub_suspended_i))
            begin
              ps_q[p] <= PS_RESUMING;
              pcnt_q[p] <= uhpc_pkg::CNT_W'(RESUME_CYC - 1);
            end
          PS_RESUMING:
            if (pcnt_q[p] == '0)
              ps_q[p] <= PS_ENABLED;
            else
              pcnt_q[p] <= pcnt_q[p] - 1'b1;
          default:
            ps_q[p] <= PS_OFF;
        endcase
    end
  end

  // sticky change flags
  // A set in the same cycle as the host's clear wins, so no change is lost.
  always_ff @(posedge clk_i)
  begin
    for (int p = 0; p < NP; p++)
    begin
      if (!resetn_i || !configured)
      begin
        conn_q[p] <= 1'b0;
        c_conn_q[p] <= 1'b0;
        c_en_q[p] <= 1'b0;
        c_susp_q[p] <= 1'b0;
        c_rst_q[p] <= 1'b0;
      end
      else
      begin
        conn_q[p] <= (ps_q[p] != PS_OFF) && port_connect_i[p];
        c_conn_q[p] <= ev_conn[p] || (c_conn_q[p] && !req_hit(uhpc_pkg::UHPC_REQ_CLR_C_CONNECT, p));
        c_en_q[p] <= ev_babble[p] || (c_en_q[p] && !req_hit(uhpc_pkg::UHPC_REQ_CLR_C_ENABLE, p));
        c_susp_q[p] <= ev_res_done[p] || (c_susp_q[p] && !req_hit(uhpc_pkg::UHPC_REQ_CLR_C_SUSPEND, p));
        c_rst_q[p] <= ev_rst_done[p] || (c_rst_q[p] && !req_hit(uhpc_pkg::UHPC_REQ_CLR_C_RESET, p));
      end
    end
  end

  // indicator override
  // A set-indicator request takes the green lamp out of automatic control; a clear-indicator request returns it.
  always_ff @(posedge clk_i)
  begin
    for (int p = 0; p < NP; p++)
    begin
      if (!resetn_i || !configured)
        ind_ovr_q[p] <= 1'b0;
      else if (req_hit(uhpc_pkg::UHPC_REQ_SET_IND, p))
        ind_ovr_q[p] <= 1'b1;
      else if (req_hit(uhpc_pkg::UHPC_REQ_CLR_IND, p))
        ind_ovr_q[p] <= 1'b0;
    end
  end

  // packet-boundary connectivity
  // Changing the path mid-packet would truncate it, so wait for a boundary.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      rep_q <= 4'h0;
    else if (pkt_boundary_i)
      for (int p = 0; p < NP; p++)
        rep_q[p] <= (ps_q[p] == PS_ENABLED) && (!hs_mode_o || port_hs_dev_i[p]);
  end

  // forward wakeup
  // Registered request, held while a suspended port signals wakeup with the hub suspended, for the upstream transmitter to drive resume.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      upstream_wakeup_o <= 1'b0;
    else
    begin
      upstream_wakeup_o <= 1'b0;
      for (int p = 0; p < NP; p++)
        if (ps_q[p] == PS_SUSPENDED && port_wakeup_i[p] && hub_suspended_i)
          upstream_wakeup_o <= 1'b1;
    end
  end

  // Per-port outputs decoded from the port machines.
  always_comb
  begin
    for (int p = 0; p < NP; p++)
    begin
      port_se0_o[p] = !configured;
      port_power_o[p] = configured && (ps_q[p] != PS_OFF);
      port_reset_o[p] = (ps_q[p] == PS_RESETTING);
      port_enabled_o[p] = (ps_q[p] == PS_ENABLED);
      port_suspended_o[p] = (ps_q[p] == PS_SUSPENDED);
      port_resume_o[p] = (ps_q[p] == PS_RESUMING);
      ind_green_o[p] = port_enabled_o[p] && !ind_ovr_q[p];
      babble_en_o[p] = port_enabled_o[p];
      route_tt_o[p] = port_enabled_o[p] && hs_mode_o && !port_hs_dev_i[p];
      us_block_o[p] = !rep_q[p] || ev_babble[p] || !port_connect_i[p];
    end
  end

  assign rep_conn_o = rep_q;
  assign fs_only_o = !hs_mode_o;

  // status change reports
  // A new bitmap is queued only when it differs from the last one sent.
  assign sc_bits = {c_conn_q | c_en_q | c_susp_q | c_rst_q, 1'b0};
  assign sc_if.valid = configured && (sc_bits != 5'h00) && (sc_bits != last_q);
  assign sc_if.data = sc_bits;

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || sc_bits == 5'h00)
      last_q <= 5'h00;
    else if (sc_if.valid && sc_if.ready)
      last_q <= sc_bits;
  end

  uhpc_sc_buf #(
    .W(SC_W_L)
  ) u_sc_buf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_if(sc_if.snk),
    .out_valid_o(sc_valid_o),
    .out_ready_i(sc_ready_i),
    .out_data_o(sc_data_o)
  );

endmodule : uhpc_hub_ctrl

// >>> verilog/uhpc_pkg.sv
package uhpc_pkg;

  // Clock rate and the derived cycle counts for timed intervals.
  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int PORT_RESET_MS = 10;
  localparam int PORT_RESUME_MS = 20;
  localparam int DEV_CHIRP_US = 1000;
  localparam int PORT_RESET_CYC = PORT_RESET_MS * 1000 * CYC_PER_US;
  localparam int PORT_RESUME_CYC = PORT_RESUME_MS * 1000 * CYC_PER_US;
  localparam int DEV_CHIRP_CYC = DEV_CHIRP_US * CYC_PER_US;
  localparam int CNT_W = 21;

  // Downstream port count and status change report width.
  localparam int NPORT = 4;
  localparam int SC_W = NPORT + 1;

  // Configuration memory fetch: read opcode, start address, byte layout.
  localparam logic [7:0] SPI_READ_CMD = 8'h03;
  localparam logic [7:0] SPI_START_ADDR = 8'h00;
  localparam int SPI_CMD_BITS = 16;
  localparam int SPI_HALF_CYC = 4;
  localparam int CFG_BYTES = 8;
  localparam int BYTE_LOAD = 0;
  localparam int BYTE_VID = 1;
  localparam int BYTE_PID = 3;
  localparam int BYTE_DID = 5;
  localparam int BYTE_PORTS = 7;
  localparam logic [7:0] LOAD_EXT_A = 8'hd2;
  localparam logic [7:0] LOAD_EXT_B = 8'hd4;
  localparam logic [3:0] PORTS_ALL = 4'hf;
  localparam logic [3:0] PORTS_NONE = 4'h0;

  // Port feature requests decoded from the host's hub class traffic.
  typedef enum logic [3:0] {
    UHPC_REQ_SET_POWER,
    UHPC_REQ_CLR_POWER,
    UHPC_REQ_SET_RESET,
    UHPC_REQ_CLR_ENABLE,
    UHPC_REQ_SET_SUSPEND,
    UHPC_REQ_CLR_SUSPEND,
    UHPC_REQ_CLR_C_CONNECT,
    UHPC_REQ_CLR_C_ENABLE,
    UHPC_REQ_CLR_C_SUSPEND,
    UHPC_REQ_CLR_C_RESET,
    UHPC_REQ_SET_IND,
    UHPC_REQ_CLR_IND
  } uhpc_req_t;

endpackage : uhpc_pkg

// >>> verilog/uhpc_sc_if.sv
`timescale 1ns/1ps
// Status change report stream between the hub logic and its buffer.
interface uhpc_sc_if;
  logic valid;
  logic ready;
  logic [uhpc_pkg::SC_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : uhpc_sc_if

// >>> verilog/uhpc_sc_buf.sv
`timescale 1ns/1ps
// Two-entry buffer so a stalled endpoint reader loses no report.
module uhpc_sc_buf #(
  parameter int W = uhpc_pkg::SC_W
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  uhpc_sc_if.snk in_if,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  logic [W-1:0] mem_q [2];
  logic [1:0] cnt_q;
  logic wr_q;
  logic rd_q;
  logic push;
  logic pop;

  // Full only at two entries, so the writer sees honest back-pressure.
  assign in_if.ready = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_if.valid && in_if.ready;
  assign pop = out_valid_o && out_ready_i;

  // Occupancy and pointers.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cnt_q <= 2'h0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
    end
  end

  // Storage; contents need no reset since valid gates them.
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_q] <= in_if.data;
  end

endmodule : uhpc_sc_buf

// >>> tb/uhpc_eeprom_model.sv
`timescale 1ns/1ps
// Serial configuration memory holding one fixed image.
module uhpc_eeprom_model (
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o
);
  // Load marker, ids and port flags; the id values are arbitrary.
  localparam logic [63:0] IMG = 64'hd2_1234_5678_9abc_3f;
  logic [15:0] cmd_q;
  int n_q = 0;
  initial miso_o = 1'b0;
  // A new frame restarts the bit count.
  always @(negedge cs_n_i) n_q = 0;
  // Collect the command on rising clocks.
  always @(posedge sck_i)
  begin
    if (!cs_n_i)
    begin
      if (n_q < 16)
        cmd_q = {cmd_q[14:0], mosi_i};
      n_q++;
    end
  end
  // image served msb first
  // Outside a read the line toggles, so a stale bit never looks valid.
  always @(negedge sck_i or posedge cs_n_i)
    if (!cs_n_i && cmd_q == 16'h0300 && n_q >= 16 && n_q < 80)
      miso_o <= IMG[79 - n_q];
    else
      miso_o <= ~miso_o;
endmodule : uhpc_eeprom_model

// >>> tb/uhpc_hub_ctrl_checker.sv
`timescale 1ns/1ps
// Temporal checks on the hub control ports.
module uhpc_hub_ctrl_checker (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cfg_done_o,
  input wire logic upstream_vbus_sense_i,
  input wire logic bus_reset_i,
  input wire logic dp_pullup_o,
  input wire logic chirp_k_o,
  input wire logic hs_mode_o,
  input wire logic [6:0] dev_addr_o,
  input wire logic [7:0] cfg_value_o,
  input wire logic hub_ready_o,
  input wire logic [3:0] port_se0_o,
  input wire logic [3:0] port_power_o,
  input wire logic [3:0] port_reset_o,
  input wire logic [3:0] port_enabled_o,
  input wire logic [3:0] babble_en_o,
  input wire logic [3:0] port_connect_i,
  input wire logic eof2_i,
  input wire logic [3:0] port_nonidle_i,
  input wire logic [3:0] port_suspended_o,
  input wire logic [3:0] port_wakeup_i,
  input wire logic hub_suspended_i,
  input wire logic upstream_wakeup_o,
  input wire logic sc_valid_o,
  input wire logic sc_ready_i,
  input wire logic [4:0] sc_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_fetch_before_attach: assert property (dp_pullup_o |-> cfg_done_o) else $error("pullup before fetch");
  a_vbus_gates_pullup: assert property (!upstream_vbus_sense_i |=> !dp_pullup_o) else $error("pullup without vbus");
  a_chirp_in_reset: assert property ($rose(chirp_k_o) |-> bus_reset_i) else $error("chirp outside reset");
  a_hs_drops_pullup: assert property (hs_mode_o |-> !dp_pullup_o) else $error("pullup in high speed");
  a_reset_clears_addr: assert property ($rose(bus_reset_i) |=> dev_addr_o == 7'h00 && cfg_value_o == 8'h00)
    else $error("address kept over reset");
  a_ready_needs_cfg: assert property (hub_ready_o |-> cfg_value_o != 8'h00) else $error("ready unconfigured");
  a_unconfig_se0_off: assert property (!hub_ready_o |-> port_se0_o == 4'hf && port_power_o == 4'h0)
    else $error("port active unconfigured");
  a_reset_then_enable: assert property ($fell(port_reset_o[0]) && port_connect_i[0] |-> port_enabled_o[0] && babble_en_o[0])
    else $error("reset end not enabled");
  a_babble_disables: assert property (port_enabled_o[0] && babble_en_o[0] && eof2_i && port_nonidle_i[0]
    |=> !port_enabled_o[0]) else $error("babble ignored");
  a_wake_forwarded: assert property (hub_suspended_i && port_suspended_o[1] && $rose(port_wakeup_i[1])
    |-> ##[1:2] upstream_wakeup_o) else $error("wakeup not forwarded");
  a_report_held: assert property (sc_valid_o && !sc_ready_i |=> sc_valid_o && $stable(sc_data_o))
    else $error("report dropped");
  c_high_speed: cover property ($rose(hs_mode_o));
  c_port_disabled: cover property ($fell(port_enabled_o[0]));
  c_wakeup_up: cover property (upstream_wakeup_o);
endmodule : uhpc_hub_ctrl_checker
bind uhpc_hub_ctrl uhpc_hub_ctrl_checker u_chk (.*);

// >>> tb/uhpc_hub_ctrl_tb.sv
`timescale 1ns/1ps
// Directed bench for the hub control block.
module usb_hub_port_control_tb;
  logic clk_i, resetn_i, spi_miso_i, upstream_vbus_sense_i, bus_reset_i, host_chirp_i, set_addr_i, set_cfg_i;
  logic req_valid_i, hub_suspended_i, eof2_i, pkt_boundary_i, sc_ready_i, req_ready_o, s;
  logic spi_cs_n_o, spi_sck_o, spi_mosi_o, cfg_done_o, dp_pullup_o, chirp_k_o, hs_mode_o, hub_ready_o;
  logic fs_only_o, upstream_wakeup_o, sc_valid_o;
  logic [6:0] addr_i, dev_addr_o;
  logic [7:0] cfg_val_i, cfg_value_o;
  logic [15:0] cfg_vid_o, cfg_pid_o, cfg_did_o;
  logic [1:0] req_port_i;
  logic [4:0] sc_data_o;
  uhpc_pkg::uhpc_req_t req_code_i;
  logic [3:0] port_connect_i, port_nonidle_i, port_hs_dev_i, port_wakeup_i, port_usable_o, port_removable_o;
  logic [3:0] port_se0_o, port_power_o, port_reset_o, port_enabled_o, port_suspended_o, port_resume_o;
  logic [3:0] ind_green_o, babble_en_o, route_tt_o, rep_conn_o, us_block_o;
  int miscompares = 0;
  int num_checks = 0;
  // Short counts keep the port timers within a few dozen cycles.
  uhpc_hub_ctrl #(.RESET_CYC(20), .RESUME_CYC(30), .CHIRP_CYC(10), .SPI_HALF(2)) uut (.*);
  uhpc_eeprom_model mem (.cs_n_i(spi_cs_n_o), .sck_i(spi_sck_o), .mosi_i(spi_mosi_o), .miso_o(spi_miso_i));
  // Free running clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Packet boundaries every other cycle keep the repeater moving.
  always @(posedge clk_i) pkt_boundary_i <= ~pkt_boundary_i;
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : cyc
  task automatic req(input uhpc_pkg::uhpc_req_t c, input logic [1:0] p);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_code_i <= c;
    req_port_i <= p;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask : req
  task automatic t_fetch();
    for (int i = 0; i < 600 && cfg_done_o !== 1'b1; i++)
      @(negedge clk_i);
    chk({cfg_vid_o, cfg_pid_o}, 32'h12345678, "ids");
    chk({cfg_did_o, port_removable_o, port_usable_o}, 24'h9abc3f, "did and flags");
    chk(dp_pullup_o, 1'b0, "attached without vbus");
    @(posedge clk_i);
    upstream_vbus_sense_i <= 1'b1;
    cyc(3);
    chk(dp_pullup_o, 1'b1, "no attach");
  endtask : t_fetch
  task automatic t_attach(input logic hs);
    @(posedge clk_i);
    bus_reset_i <= 1'b1;
    cyc(2);
    chk({chirp_k_o, dev_addr_o, cfg_value_o}, 16'h8000, "chirp or address");
    cyc(12);
    @(posedge clk_i);
    host_chirp_i <= hs;
    cyc(2);
    @(posedge clk_i);
    bus_reset_i <= 1'b0;
    host_chirp_i <= 1'b0;
    cyc(2);
    chk({hs_mode_o, fs_only_o, dp_pullup_o}, hs ? 3'b100 : 3'b011, "speed");
    chk({hub_ready_o, port_se0_o, port_power_o}, 9'h0f0, "ports unconfigured");
  endtask : t_attach
  task automatic t_enum();
    req(uhpc_pkg::UHPC_REQ_SET_POWER, 2'd0);
    chk(port_power_o, 4'h0, "powered unconfigured");
    @(posedge clk_i);
    set_addr_i <= 1'b1;
    addr_i <= 7'h05;
    @(posedge clk_i);
    set_addr_i <= 1'b0;
    set_cfg_i <= 1'b1;
    cfg_val_i <= 8'h01;
    @(posedge clk_i);
    set_cfg_i <= 1'b0;
    cyc(1);
    chk({dev_addr_o, cfg_value_o, hub_ready_o, port_se0_o}, {7'h05, 8'h01, 1'b1, 4'h0}, "configure");
  endtask : t_enum
  task automatic t_ports();
    req(uhpc_pkg::UHPC_REQ_SET_POWER, 2'd0);
    req(uhpc_pkg::UHPC_REQ_SET_POWER, 2'd1);
    @(posedge clk_i);
    port_connect_i <= 4'h3;
    port_hs_dev_i <= 4'h2;
    cyc(12);
    chk({sc_valid_o, sc_data_o, port_power_o}, 10'h263, "connect report held");
    @(posedge clk_i);
    sc_ready_i <= 1'b1;
    req(uhpc_pkg::UHPC_REQ_SET_RESET, 2'd0);
    req(uhpc_pkg::UHPC_REQ_SET_RESET, 2'd1);
    chk(port_reset_o, 4'h3, "resetting");
    cyc(22);
    chk({port_enabled_o, ind_green_o, babble_en_o, route_tt_o, rep_conn_o, us_block_o}, 24'h33312d, "route");
    req(uhpc_pkg::UHPC_REQ_SET_SUSPEND, 2'd1);
    chk({port_enabled_o, port_suspended_o}, 8'h12, "suspend one");
    @(posedge clk_i);
    hub_suspended_i <= 1'b1;
    port_wakeup_i <= 4'h2;
    s = 1'b0;
    repeat (4)
    begin
      @(negedge clk_i);
      s = s | upstream_wakeup_o;
    end
    chk({s, port_suspended_o}, 5'h12, "wakeup upstream");
    @(posedge clk_i);
    hub_suspended_i <= 1'b0;
    port_wakeup_i <= 4'h0;
    req(uhpc_pkg::UHPC_REQ_CLR_SUSPEND, 2'd1);
    chk(port_resume_o, 4'h2, "resume");
    cyc(32);
    chk({port_enabled_o, port_suspended_o}, 8'h30, "resumed");
    req(uhpc_pkg::UHPC_REQ_SET_SUSPEND, 2'd1);
    @(posedge clk_i);
    port_wakeup_i <= 4'h2;
    @(posedge clk_i);
    port_wakeup_i <= 4'h0;
    cyc(1);
    chk(port_resume_o, 4'h2, "wakeup awake");
    cyc(32);
    @(posedge clk_i);
    eof2_i <= 1'b1;
    port_nonidle_i <= 4'h1;
    @(posedge clk_i);
    eof2_i <= 1'b0;
    port_nonidle_i <= 4'h0;
    cyc(1);
    chk(port_enabled_o, 4'h2, "babble");
    req(uhpc_pkg::UHPC_REQ_CLR_ENABLE, 2'd1);
    chk(port_enabled_o, 4'h0, "clear enable");
  endtask : t_ports
  // Watchdog sized well past the expected several hundred cycles.
  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  // Main sequence.
  initial
  begin
    {resetn_i, upstream_vbus_sense_i, bus_reset_i, host_chirp_i, set_addr_i, set_cfg_i, req_valid_i} = '0;
    {hub_suspended_i, eof2_i, pkt_boundary_i, sc_ready_i, addr_i, cfg_val_i, req_port_i} = '0;
    {port_connect_i, port_nonidle_i, port_hs_dev_i, port_wakeup_i} = '0;
    req_code_i = uhpc_pkg::UHPC_REQ_SET_POWER;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_fetch();
    t_attach(1'b1);
    t_enum();
    t_ports();
    t_attach(1'b0);
    tally_and_finish();
  end
endmodule : usb_hub_port_control_tb
